/* File: src/cps_pkg.sv */
// Shared constants and types for the configuration power-on sequencer.
// It assumes one 200 MHz clock and a 32-bit Avalon-MM register slave.
package cps_pkg;

	// Clock rate in MHz; all delays below are derived from it.
	localparam int CLOCK_MHZ = 200;
	// Power-on delay times in milliseconds, as selected by the pin.
	localparam int POR_FAST_MS = 2;
	localparam int POR_SLOW_MS = 100;
	// Delay counts in cycles; both exceed 4096, so the top takes them as
	// parameters with these values as defaults.
	localparam int POR_FAST_CYCLES = POR_FAST_MS * CLOCK_MHZ * 1000;
	localparam int POR_SLOW_CYCLES = POR_SLOW_MS * CLOCK_MHZ * 1000;
	// Counter width; 2^25 covers the slow delay.
	localparam int POR_CNT_W = 25;

	// Register byte offsets.
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_STATUS = 5'h04;
	localparam logic [4:0] OFS_IRQ_STATUS = 5'h08;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h0c;
	localparam logic [4:0] OFS_CLKDIV = 5'h10;

	// Control register fields and reset values.
	localparam int CTRL_EXT_CLK_BIT = 0;
	localparam logic [7:0] CLKDIV_RESET = 8'h01;
	localparam logic [5:0] IRQ_MASK_RESET = 6'h00;

	// Interrupt event bit positions.
	localparam int IRQ_RELEASED = 0;
	localparam int IRQ_FPGA_ERROR = 1;
	localparam int IRQ_CONFIG_ERROR = 2;
	localparam int IRQ_USER_MODE = 3;
	localparam int IRQ_DEAD_IDLE = 4;
	localparam int IRQ_SUPPLY_LOST = 5;
	localparam int IRQ_W = 6;

	// Sequencer states, one-hot.
	typedef enum logic [4:0] {
		CPS_HOLD = 5'h01,
		CPS_WAIT_RISE = 5'h02,
		CPS_CONFIG = 5'h04,
		CPS_USER = 5'h08,
		CPS_DEAD = 5'h10
	} cps_state_t;

	// Asynchronous pin inputs that travel together through the synchroniser.
	typedef struct packed {
		logic supply_ok;
		logic reset_delay_select;
		logic start_line;
		logic fpga_error_flag_n;
		logic conf_done;
		logic ext_clock_in;
		logic [2:0] page_select;
	} cps_pins_t;

endpackage

/* File: src/cps_sequencer.sv */
// Power-on reset and configuration-start sequencer with register slave.
// Assumes all pin inputs are asynchronous to i_clock and that the data
// engine on the same clock reports i_load_done when all data has gone out.
//
// The register addresses and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module cps_sequencer #(
	parameter logic [cps_pkg::POR_CNT_W-1:0] POR_FAST_CYCLES =
		cps_pkg::POR_CNT_W'(cps_pkg::POR_FAST_CYCLES),
	parameter logic [cps_pkg::POR_CNT_W-1:0] POR_SLOW_CYCLES =
		cps_pkg::POR_CNT_W'(cps_pkg::POR_SLOW_CYCLES)
) (
	input wire logic i_clock,
	input wire logic i_reset_n,
	// Asynchronous pins.
	input wire logic i_supply_ok,
	input wire logic i_reset_delay_select,
	input wire logic i_start_line,
	input wire logic i_fpga_error_flag_n,
	input wire logic i_conf_done,
	input wire logic i_ext_clock_in,
	input wire logic [2:0] i_page_select,
	// Same-clock report from the data engine.
	input wire logic i_load_done,
	// Open-drain start line; the pin output is always low.
	output logic o_start_line_out,
	output logic o_start_line_oe,
	output logic o_config_clock_out,
	output logic o_config_active,
	output logic [2:0] o_page_select,
	output logic o_irq,
	// Avalon-MM slave.
	input wire logic [4:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	output logic [31:0] o_readdata,
	output logic o_waitrequest
);

	// Register hit decode, used by the read mux and every write.
	function automatic logic reg_hit(input logic [4:0] addr,
		input logic [4:0] ofs);
		reg_hit = (addr == ofs);
	endfunction

	// Two-stage synchroniser; only stage two is read by logic.
	cps_pkg::cps_pins_t pins_raw;
	cps_pkg::cps_pins_t sync1_reg;
	cps_pkg::cps_pins_t pins_reg;
	// Sequencer state and its next value.
	cps_pkg::cps_state_t state_reg;
	cps_pkg::cps_state_t state_next;
	// Delay counter and the limit chosen by the select pin.
	logic [cps_pkg::POR_CNT_W-1:0] por_count_reg;
	logic [cps_pkg::POR_CNT_W-1:0] por_limit;
	logic por_expired;
	// Configuration clock generation.
	logic [7:0] div_count_reg;
	logic cfg_clk_reg;
	// Registers reached by software.
	logic ctrl_ext_clk_reg;
	logic [7:0] clkdiv_reg;
	logic [cps_pkg::IRQ_W-1:0] irq_status_reg;
	logic [cps_pkg::IRQ_W-1:0] irq_status_next;
	logic [cps_pkg::IRQ_W-1:0] irq_mask_reg;
	logic [cps_pkg::IRQ_W-1:0] irq_events;
	logic irq_reg;
	// Bus handshake and read data.
	logic waitreq_reg;
	logic [31:0] readdata_reg;
	logic [31:0] rd_mux;
	logic bus_req;
	logic wr_accept;
	logic rd_accept;
	// Outputs held in flops.
	logic oe_drive_reg;
	logic [2:0] page_reg;
	// Transition and condition decode.
	logic in_hold;
	logic in_config;
	logic in_user;
	logic in_dead;
	logic supply_lost;
	logic fpga_err;
	logic cfg_err;
	logic line_high;

	// Bundle the raw pins so they cross together.
	assign pins_raw = '{
		supply_ok: i_supply_ok,
		reset_delay_select: i_reset_delay_select,
		start_line: i_start_line,
		fpga_error_flag_n: i_fpga_error_flag_n,
		conf_done: i_conf_done,
		ext_clock_in: i_ext_clock_in,
		page_select: i_page_select
	};

	// Synchroniser flops: reset to all zeros, never to port values.
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync1_reg <= '0;
			pins_reg <= '0;
		end else begin
			sync1_reg <= pins_raw;
			pins_reg <= sync1_reg;
		end
	end

	// State decode.
	assign in_hold = (state_reg == cps_pkg::CPS_HOLD);
	assign in_config = (state_reg == cps_pkg::CPS_CONFIG);
	assign in_user = (state_reg == cps_pkg::CPS_USER);
	assign in_dead = (state_reg == cps_pkg::CPS_DEAD);

	// A supply drop after the supply was good resets from any state.
	assign supply_lost = !pins_reg.supply_ok;
	// The FPGA pulls its flag low on CRC error or a reconfiguration request.
	assign fpga_err = !pins_reg.fpga_error_flag_n;
	// All data sent but completion still low is a failed load.
	assign cfg_err = in_config && i_load_done && !pins_reg.conf_done;
	// The shared line reads high only when nobody holds it low.
	assign line_high = pins_reg.start_line;

	// High select gives the short delay, low the long one.
	assign por_limit = pins_reg.reset_delay_select ?
		POR_FAST_CYCLES : POR_SLOW_CYCLES;
	assign por_expired = (por_count_reg >= por_limit);

	// Next state: supply loss outranks all and is the only exit from dead.
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			cps_pkg::CPS_HOLD: begin
				// Release only with a good supply and an expired delay.
				if (!supply_lost && por_expired) begin
					state_next = cps_pkg::CPS_WAIT_RISE;
				end
			end
			cps_pkg::CPS_WAIT_RISE: begin
				// Sample completion on the rising line.
				if (supply_lost) begin
					state_next = cps_pkg::CPS_HOLD;
				end else if (line_high && pins_reg.conf_done) begin
					state_next = cps_pkg::CPS_DEAD;
				end else if (line_high) begin
					state_next = cps_pkg::CPS_CONFIG;
				end
			end
			cps_pkg::CPS_CONFIG: begin
				if (supply_lost || fpga_err || cfg_err) begin
					state_next = cps_pkg::CPS_HOLD;
				end else if (pins_reg.conf_done) begin
					state_next = cps_pkg::CPS_USER;
				end
			end
			cps_pkg::CPS_USER: begin
				// The FPGA may still request reconfiguration here.
				if (supply_lost || fpga_err) begin
					state_next = cps_pkg::CPS_HOLD;
				end
			end
			cps_pkg::CPS_DEAD: begin
				// Only a power-down gets out; error flag is ignored.
				if (supply_lost) begin
					state_next = cps_pkg::CPS_HOLD;
				end
			end
			default: begin
				// Illegal code: fall back to holding reset.
				state_next = cps_pkg::CPS_HOLD;
			end
		endcase
	end

	// State register; reset starts in the hold state.
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg <= cps_pkg::CPS_HOLD;
		end else begin
			state_reg <= state_next;
		end
	end

	// Delay counter: cleared outside hold or with a bad supply, so restarts.
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			por_count_reg <= '0;
		end else if (!in_hold || supply_lost) begin
			por_count_reg <= '0;
		end else if (!por_expired) begin
			por_count_reg <= por_count_reg + 1'b1;
		end
	end

	// Drive the start line low in hold; the page is caught at the rise.
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			oe_drive_reg <= 1'b1;
			page_reg <= 3'h0;
		end else begin
			oe_drive_reg <= (state_next == cps_pkg::CPS_HOLD);
			if (state_reg == cps_pkg::CPS_WAIT_RISE &&
				state_next == cps_pkg::CPS_CONFIG) begin
				page_reg <= pins_reg.page_select;
			end
		end
	end

	// Configuration clock from the divider or the synchronised external
	// pin. It sits low outside configuration, so the pin cannot reach user
	// mode; sampling limits it to at most half the clock.
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			div_count_reg <= 8'h00;
			cfg_clk_reg <= 1'b0;
		end else if (!in_config) begin
			div_count_reg <= 8'h00;
			cfg_clk_reg <= 1'b0;
		end else if (ctrl_ext_clk_reg) begin
			div_count_reg <= 8'h00;
			cfg_clk_reg <= pins_reg.ext_clock_in;
		end else if (div_count_reg >= clkdiv_reg) begin
			div_count_reg <= 8'h00;
			cfg_clk_reg <= !cfg_clk_reg;
		end else begin
			div_count_reg <= div_count_reg + 8'h01;
		end
	end

	// Events that set sticky interrupt bits.
	assign irq_events[cps_pkg::IRQ_RELEASED] =
		in_hold && state_next == cps_pkg::CPS_WAIT_RISE;
	assign irq_events[cps_pkg::IRQ_FPGA_ERROR] =
		(in_config || in_user) && fpga_err && !supply_lost;
	assign irq_events[cps_pkg::IRQ_CONFIG_ERROR] =
		cfg_err && !fpga_err && !supply_lost;
	assign irq_events[cps_pkg::IRQ_USER_MODE] =
		in_config && state_next == cps_pkg::CPS_USER;
	assign irq_events[cps_pkg::IRQ_DEAD_IDLE] =
		!in_dead && state_next == cps_pkg::CPS_DEAD;
	assign irq_events[cps_pkg::IRQ_SUPPLY_LOST] =
		!in_hold && supply_lost;

	// Bus handshake: waitrequest drops for one cycle after each request.
	assign bus_req = i_read || i_write;
	assign wr_accept = i_write && !waitreq_reg;
	assign rd_accept = i_read && !waitreq_reg;

	// Read-to-clear drops only the bits captured for the master, so an
	// event landing between capture and clear is never lost.
	assign irq_status_next = (rd_accept &&
		reg_hit(i_address, cps_pkg::OFS_IRQ_STATUS)) ?
		((irq_status_reg & ~readdata_reg[cps_pkg::IRQ_W-1:0]) | irq_events) :
		(irq_status_reg | irq_events);

	// Read mux; unmapped addresses read zero.
	assign rd_mux =
		reg_hit(i_address, cps_pkg::OFS_CTRL) ?
			{31'h0, ctrl_ext_clk_reg} :
		reg_hit(i_address, cps_pkg::OFS_STATUS) ?
			{19'h0, pins_reg.fpga_error_flag_n, pins_reg.conf_done,
			pins_reg.start_line, pins_reg.supply_ok,
			pins_reg.reset_delay_select, page_reg, state_reg} :
		reg_hit(i_address, cps_pkg::OFS_IRQ_STATUS) ?
			{26'h0, irq_status_reg} :
		reg_hit(i_address, cps_pkg::OFS_IRQ_MASK) ?
			{26'h0, irq_mask_reg} :
		reg_hit(i_address, cps_pkg::OFS_CLKDIV) ?
			{24'h0, clkdiv_reg} : 32'h0000_0000;

	// Read data is captured while waitrequest is high, ahead of the answer.
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			waitreq_reg <= 1'b1;
			readdata_reg <= 32'h0000_0000;
		end else begin
			waitreq_reg <= !(bus_req && waitreq_reg);
			if (i_read && waitreq_reg) begin
				readdata_reg <= rd_mux;
			end
		end
	end

	// Writable registers take effect at the accepting edge.
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl_ext_clk_reg <= 1'b0;
			clkdiv_reg <= cps_pkg::CLKDIV_RESET;
			irq_mask_reg <= cps_pkg::IRQ_MASK_RESET;
		end else if (wr_accept) begin
			if (reg_hit(i_address, cps_pkg::OFS_CTRL)) begin
				ctrl_ext_clk_reg <= i_writedata[cps_pkg::CTRL_EXT_CLK_BIT];
			end
			if (reg_hit(i_address, cps_pkg::OFS_IRQ_MASK)) begin
				irq_mask_reg <= i_writedata[cps_pkg::IRQ_W-1:0];
			end
			if (reg_hit(i_address, cps_pkg::OFS_CLKDIV)) begin
				clkdiv_reg <= i_writedata[7:0];
			end
		end
	end

	// Sticky status and the level interrupt output.
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			irq_status_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			irq_status_reg <= irq_status_next;
			irq_reg <= |(irq_status_next & irq_mask_reg);
		end
	end

	// Outputs come from flops, except the tied-low o_start_line_out and the state decode o_config_active.
	assign o_start_line_out = 1'b0;
	assign o_start_line_oe = oe_drive_reg;
	assign o_config_clock_out = cfg_clk_reg;
	assign o_config_active = in_config;
	assign o_page_select = page_reg;
	assign o_irq = irq_reg;
	assign o_readdata = readdata_reg;
	assign o_waitrequest = waitreq_reg;

endmodule

`default_nettype wire

/* File: verification/cps_sequencer_sva.sv */
// Assertion checker for the configuration power-on sequencer.
// Sees only the top module's ports and is bound to every instance.
`timescale 1ns/1ps
`default_nettype none
module cps_sequencer_chk #(
	parameter int POR_FAST_CYCLES = 20,
	parameter int POR_SLOW_CYCLES = 60
) (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_supply_ok,
	input wire logic i_reset_delay_select,
	input wire logic i_start_line,
	input wire logic i_fpga_error_flag_n,
	input wire logic i_conf_done,
	input wire logic i_load_done,
	input wire logic [2:0] i_page_select,
	input wire logic o_start_line_oe,
	input wire logic o_config_clock_out,
	input wire logic o_config_active,
	input wire logic [2:0] o_page_select
);
	// Cycles with the line held and supply good; zero otherwise.
	int held_cnt;
	// Delay picked by the pin now; select is kept steady during a hold.
	int limit;
	assign limit = i_reset_delay_select ? POR_FAST_CYCLES : POR_SLOW_CYCLES;
	// The count starts at the pin, ahead of the sync, so it bounds loosely.
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			held_cnt <= 0;
		end else if (!i_supply_ok || !o_start_line_oe) begin
			held_cnt <= 0;
		end else begin
			held_cnt <= held_cnt + 1;
		end
	end
	default clocking dcb @(posedge i_clock);
	endclocking
	default disable iff (!i_reset_n);
	a_supply_loss: assert property (
		!i_supply_ok |-> ##[0:4] o_start_line_oe)
		else $error("line not held after supply loss");
	a_early_release: assert property (
		$fell(o_start_line_oe) |-> held_cnt >= limit)
		else $error("line released before the delay ran out");
	a_late_release: assert property (
		o_start_line_oe |-> held_cnt <= limit + 5)
		else $error("line held past the delay");
	a_clock_static: assert property (
		!o_config_active && !$past(o_config_active) |-> !o_config_clock_out)
		else $error("config clock moved outside configuration");
	a_error_restart: assert property (
		(!o_start_line_oe && o_config_active && !i_fpga_error_flag_n) ##1
		!i_fpga_error_flag_n [*2] |-> ##[0:2] o_start_line_oe)
		else $error("error flag did not restart");
	// The data engine report is same-clock, so no sync lag applies; the
	// model drops it soon after the restart, hence no repetition here.
	a_load_error: assert property (
		o_config_active && i_load_done && !i_conf_done |->
		##[1:3] o_start_line_oe)
		else $error("failed load did not restart");
	a_config_start: assert property (
		$rose(o_config_active) |->
		$past(i_start_line, 3) && !$past(i_conf_done, 3))
		else $error("configuration began without a clean line rise");
	a_page_latch: assert property (
		$rose(o_config_active) |-> o_page_select == $past(i_page_select, 3))
		else $error("page not taken at configuration start");
endmodule
bind cps_sequencer cps_sequencer_chk #(
	.POR_FAST_CYCLES(POR_FAST_CYCLES),
	.POR_SLOW_CYCLES(POR_SLOW_CYCLES)
) chk_u (
	.i_clock(i_clock), .i_reset_n(i_reset_n), .i_supply_ok(i_supply_ok),
	.i_reset_delay_select(i_reset_delay_select),
	.i_start_line(i_start_line), .i_fpga_error_flag_n(i_fpga_error_flag_n),
	.i_conf_done(i_conf_done), .i_load_done(i_load_done),
	.i_page_select(i_page_select), .o_start_line_oe(o_start_line_oe),
	.o_config_clock_out(o_config_clock_out),
	.o_config_active(o_config_active), .o_page_select(o_page_select)
);
`default_nettype wire

/* File: verification/cps_fpga_model.sv */
// Model of the FPGA, its data engine and the pulled-up start wire.
// Assumes the sequencer clock; bench controls power and faults.
`timescale 1ns/1ps
`default_nettype none
module cps_fpga_model #(
	parameter int N_EDGES = 8
) (
	input wire logic i_clock,
	input wire logic i_start_line_oe,
	input wire logic i_config_clock,
	input wire logic i_hold_low,
	input wire logic i_powered,
	input wire logic i_load_good,
	input wire logic i_error_req,
	output logic o_line,
	output logic o_conf_done,
	output logic o_error_flag_n,
	output logic o_load_done
);
	// Config clock rising edges seen since the wire last rose.
	int edges = 0;
	logic clk_q = 1'b0;
	// Pulled-up wire; a power-good hold keeps it low like the device.
	assign o_line = !(i_start_line_oe || i_hold_low);
	assign o_error_flag_n = !i_error_req;
	// Unpowered, completion floats high on its pull-up.
	assign o_conf_done = !i_powered || (i_load_good && edges >= N_EDGES);
	// The engine reports one edge after completion, so sync lag is covered.
	assign o_load_done = edges > N_EDGES;
	// Wire low resets the FPGA and the data count.
	always @(posedge i_clock) begin
		clk_q <= i_config_clock;
		if (!o_line) begin
			edges <= 0;
		end else if (i_config_clock && !clk_q) begin
			edges <= edges + 1;
		end
	end
endmodule
`default_nettype wire

/* File: verification/cps_testbench.sv */
// Self-checking bench for the sequencer with the FPGA model.
// Assumes the checker is bound; delays are shortened to 20 and 60.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
	error_cnt++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module testbench;
	localparam int FAST = 20;
	localparam int SLOW = 60;
	logic i_clock = 1'b0;
	logic i_reset_n = 1'b0;
	logic supply = 1'b0, sel = 1'b1, ext_clk = 1'b0, hold = 1'b0;
	logic powered = 1'b1, good = 1'b1, err = 1'b0, rd = 1'b0, wr = 1'b0;
	logic [2:0] page = 3'h0;
	logic [4:0] addr = 5'h00;
	logic [31:0] wdata = 32'h0;
	logic line, done, flag_n, load_done, oe, cclk, active, irq, wait_req;
	logic line_out;
	logic [2:0] page_out;
	logic [31:0] rdata;
	int error_cnt = 0;
	int num_checks = 0;
	// Half period of 2.5 ns gives 200 MHz.
	always #2.5 i_clock = !i_clock;
	// External clock toggles freely, also in user mode.
	always @(posedge i_clock) ext_clk <= !ext_clk;
	cps_sequencer #(.POR_FAST_CYCLES(25'(FAST)), .POR_SLOW_CYCLES(25'(SLOW)))
	dut_u (
		.i_clock(i_clock), .i_reset_n(i_reset_n), .i_supply_ok(supply),
		.i_reset_delay_select(sel), .i_start_line(line),
		.i_fpga_error_flag_n(flag_n), .i_conf_done(done),
		.i_ext_clock_in(ext_clk), .i_page_select(page),
		.i_load_done(load_done), .o_start_line_out(line_out),
		.o_start_line_oe(oe), .o_config_clock_out(cclk),
		.o_config_active(active), .o_page_select(page_out), .o_irq(irq),
		.i_address(addr), .i_read(rd), .i_write(wr), .i_writedata(wdata),
		.o_readdata(rdata), .o_waitrequest(wait_req)
	);
	cps_fpga_model fpga_u (
		.i_clock(i_clock), .i_start_line_oe(oe), .i_config_clock(cclk),
		.i_hold_low(hold), .i_powered(powered), .i_load_good(good),
		.i_error_req(err), .o_line(line), .o_conf_done(done),
		.o_error_flag_n(flag_n), .o_load_done(load_done)
	);
	// One bus transfer; request held until waitrequest is seen low.
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		// Only the watchdog bounds this wait; the slave answers one cycle
		// after it takes the request, so the answer edge is the second.
		do begin
			@(posedge i_clock);
			n++;
		end while (wait_req !== 1'b0);
		q = rdata;
		`CHK("bus answer", 2, n)
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge i_clock);
	endtask
	task automatic rd_chk(input logic [4:0] a, input logic [31:0] ex);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		`CHK("register", ex, q)
	endtask
	task automatic wait_oe(input logic v, output int n);
		n = 0;
		while (oe !== v && n < 2000) begin
			@(posedge i_clock);
			n++;
		end
	endtask
	// Power or restart, hold the wire a while, then let the FPGA start.
	task automatic boot(input logic s, input int lim, input logic [2:0] p,
		input logic dead);
		int n;
		hold <= 1'b1;
		page <= p;
		sel <= s;
		supply <= 1'b1;
		wait_oe(1'b0, n);
		`CHK("release", 1'b1, n >= lim - 2 && n <= lim + 6)
		// No test-port work is started before the reset period is over.
		repeat (6) @(posedge i_clock);
		`CHK("held", 1'b0, active)
		hold <= 1'b0;
		// The rise needs two sync stages and one state edge to land.
		repeat (4) @(posedge i_clock);
		n = 0;
		while (active !== !dead && n < 20) begin
			@(posedge i_clock);
			n++;
		end
		`CHK("start", !dead, active)
		if (!dead) `CHK("page", p, page_out)
	endtask
	// Let configuration finish; oe tells user mode from a failed load.
	task automatic finish_cfg(input logic oe_ex);
		int n;
		n = 0;
		while (active !== 1'b0 && n < 200) begin
			@(posedge i_clock);
			n++;
		end
		`CHK("after load", oe_ex, oe)
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Far longer than the whole sequence needs.
	initial begin
		repeat (20000) @(posedge i_clock);
		error_cnt++;
		test_done();
	end
	initial begin
		int n;
		logic [31:0] q;
		repeat (5) @(posedge i_clock);
		i_reset_n <= 1'b1;
		@(posedge i_clock);
		rd_chk(cps_pkg::OFS_CTRL, 32'h0);
		rd_chk(cps_pkg::OFS_IRQ_MASK, 32'h0);
		rd_chk(cps_pkg::OFS_CLKDIV, 32'h1);
		// A slower internal clock stretches each divider-clocked load over more cycles.
		bus(1'b1, cps_pkg::OFS_CLKDIV, 32'h2, q);
		rd_chk(cps_pkg::OFS_CLKDIV, 32'h2);
		bus(1'b1, 5'h14, 32'hffff_ffff, q);
		rd_chk(5'h14, 32'h0);
		bus(1'b1, cps_pkg::OFS_IRQ_MASK, 32'h8, q);
		boot(1'b1, FAST, 3'h5, 1'b0);
		finish_cfg(1'b0);
		bus(1'b1, cps_pkg::OFS_CTRL, 32'h1, q);
		repeat (20) @(posedge i_clock);
		`CHK("user clock", 1'b0, cclk)
		bus(1'b1, cps_pkg::OFS_CTRL, 32'h0, q);
		`CHK("irq up", 1'b1, irq)
		rd_chk(cps_pkg::OFS_IRQ_STATUS, 32'h9);
		`CHK("irq cleared", 1'b0, irq)
		// A reconfiguration request from user mode.
		err <= 1'b1;
		wait_oe(1'b1, n);
		`CHK("error restart", 1'b1, n <= 6)
		err <= 1'b0;
		boot(1'b1, FAST, 3'h7, 1'b0);
		// The same request while data is still going out.
		err <= 1'b1;
		wait_oe(1'b1, n);
		`CHK("error in config", 1'b1, n <= 6)
		err <= 1'b0;
		good <= 1'b0;
		boot(1'b1, FAST, 3'h7, 1'b0);
		finish_cfg(1'b1);
		`CHK("irq masked", 1'b0, irq)
		rd_chk(cps_pkg::OFS_IRQ_STATUS, 32'h7);
		good <= 1'b1;
		boot(1'b0, SLOW, 3'h2, 1'b0);
		// This load finishes on the external clock.
		bus(1'b1, cps_pkg::OFS_CTRL, 32'h1, q);
		finish_cfg(1'b0);
		supply <= 1'b0;
		wait_oe(1'b1, n);
		`CHK("supply loss", 1'b1, n <= 6)
		powered <= 1'b0;
		boot(1'b1, FAST, 3'h0, 1'b1);
		bus(1'b0, cps_pkg::OFS_STATUS, 32'h0, q);
		`CHK("dead state", 5'h10, q[4:0])
		err <= 1'b1;
		repeat (10) @(posedge i_clock);
		`CHK("dead stays", 1'b0, oe)
		err <= 1'b0;
		powered <= 1'b1;
		supply <= 1'b0;
		repeat (6) @(posedge i_clock);
		boot(1'b1, FAST, 3'h3, 1'b0);
		`CHK("line out", 1'b0, line_out)
		test_done();
	end
endmodule
`default_nettype wire
